//--- logic/fmsp_pkg.sv
package fmsp_pkg;
    // Mode field values, binary value equals the mode number
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_UART8 = 2'h1;
    localparam logic [1:0] MODE_UART9_FIXED = 2'h2;
    localparam logic [1:0] MODE_UART9_VAR = 2'h3;

    // Clock figures
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;

    // Mode 0 bit period is the oscillator divided by twelve
    localparam int SHIFT_DIV = 12;
    localparam logic [3:0] SHIFT_LAST = 4'(SHIFT_DIV - 1);
    localparam logic [3:0] SHIFT_HIGH_FROM = 4'(SHIFT_DIV / 2);

    // Asynchronous modes sample at sixteen times the bit rate
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] OVS_LAST = 4'(OVERSAMPLE - 1);
    localparam logic [3:0] OVS_MIDDLE = 4'(OVERSAMPLE / 2 - 1);
    // Mode 2: 64 or 32 clocks per bit, so 4 or 2 clocks per tick
    localparam int FIXED_DIV_SLOW = 64 / OVERSAMPLE;
    localparam int FIXED_DIV_FAST = 32 / OVERSAMPLE;
    localparam logic [1:0] FIXED_LIM_SLOW = 2'(FIXED_DIV_SLOW - 1);
    localparam logic [1:0] FIXED_LIM_FAST = 2'(FIXED_DIV_FAST - 1);
    // Modes 1 and 3: overflow rate over 32, doubled by the doubler
    localparam int OVF_DIV_SLOW = 32 / OVERSAMPLE;
    localparam logic [1:0] OVF_LIM_SLOW = 2'(OVF_DIV_SLOW - 1);
    localparam logic [1:0] OVF_LIM_FAST = 2'h0;

    // Frame sizes in bits, start and stop included in the asynchronous frames, not in mode 0
    localparam int DATA_W = 8;
    localparam logic [3:0] FRAME8_BITS = 4'ha;
    localparam logic [3:0] FRAME9_BITS = 4'hb;
    localparam logic [3:0] SHIFT_BITS = 4'h8;

    // Transmit queue
    localparam int TXQ_DEPTH = 8;

    // Reset values
    localparam logic [7:0] HOLD_RESET = 8'h00;
    localparam logic [10:0] TX_SHREG_RESET = 11'h7ff;
endpackage : fmsp_pkg

//--- logic/fmsp_sync.sv
`timescale 1ns/1ns
`default_nettype none
module fmsp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // Two stages; idle line level is high, so reset to ones
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_ff <= '1;
            sync_ff <= '1;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule : fmsp_sync
`default_nettype wire

//--- logic/fmsp_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module fmsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
    localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PTR_W-1:0] wr_ptr_ff;
    logic [PTR_W-1:0] rd_ptr_ff;
    logic [CNT_W-1:0] count_ff;
    logic [CNT_W-1:0] nxt_count;
    logic not_full_ff;
    logic push;
    logic pop;

    assign push = in_valid_in && not_full_ff;
    assign pop = out_ready_in && (count_ff != '0);

    // Occupancy; ready is registered so the top sees it from a flop
    always_comb begin
        nxt_count = count_ff;
        if (push && !pop) begin
            nxt_count = count_ff + 1'b1;
        end else if (pop && !push) begin
            nxt_count = count_ff - 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_ff <= '0;
            not_full_ff <= 1'b1;
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            count_ff <= nxt_count;
            not_full_ff <= (nxt_count != FULL_COUNT);
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + 1'b1;
            end
        end
    end

    // Storage words, written by index
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_in;
        end
    end

    assign in_ready_out = not_full_ff;
    assign out_valid_out = (count_ff != '0);
    assign out_data_out = mem_ff[rd_ptr_ff];
endmodule : fmsp_fifo
`default_nettype wire

//--- logic/fmsp_serial_port.sv
// Operation
// - Transmit and receive run at once, except in mode 0
// - Async receive shifts while holding register unread
// - Overrun loses one of two characters
// - Write loads transmit, read returns holding register
// - Mode 0 data on data pin, clock out
// - Mode 0 bit rate is clock/12
// - Mode 1 frame start, 8 data, stop
// - Mode 1 stop bit into ninth flag
// - Mode 2 eleven bits, ninth from control
// - Mode 2 ninth bit stored, stop ignored
// - Mode 2 rate clock/32 or clock/64
// - Doubler 0 gives /64, 1 gives /32
// - Mode 3 equals mode 2 except rate
// - Modes 1,3 rate from timer overflow/32, or overflow/16 with the doubler set
// - Any buffer write accepted by the queue starts a transmission
// - Mode 0 receive when enabled, done clear
// - Async receive starts on start bit, enabled
// - Filter set: done only if ninth bit 1
// - Filter ignored in mode 0
// - Mode 1 filter: done only on stop 1
`timescale 1ns/1ns
`default_nettype none
module fmsp_serial_port (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] mode_in,
    input wire logic multiprocessor_filter_in,
    input wire logic receive_enable_in,
    input wire logic transmit_ninth_bit_in,
    input wire logic baud_doubler_in,
    input wire logic timer1_overflow_in,
    input wire logic serial_buffer_write_in,
    input wire logic [7:0] serial_buffer_wdata_in,
    output logic serial_buffer_ready_out,
    output logic [7:0] serial_buffer_rdata_out,
    output logic received_ninth_bit_out,
    output logic transmit_done_flag_out,
    output logic receive_done_flag_out,
    input wire logic transmit_done_clear_in,
    input wire logic receive_done_clear_in,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe_n_out,
    output logic txd_out
);
    typedef enum logic [2:0] {
        FMSP_IDLE = 3'h1,
        FMSP_SYNC = 3'h2,
        FMSP_ASYNC = 3'h4
    } fmsp_state_type;

    // Nine-bit frame decode, used by both directions
    function automatic logic fmsp_nine_bit(input logic [1:0] mode);
        fmsp_nine_bit = (mode == fmsp_pkg::MODE_UART9_FIXED) || (mode == fmsp_pkg::MODE_UART9_VAR);
    endfunction : fmsp_nine_bit

    function automatic logic [3:0] fmsp_frame_bits(input logic [1:0] mode);
        fmsp_frame_bits = fmsp_nine_bit(mode) ? fmsp_pkg::FRAME9_BITS : fmsp_pkg::FRAME8_BITS;
    endfunction : fmsp_frame_bits

    logic rst_meta_ff;
    logic rst_sync_ff;
    logic rst_n;
    logic rxd_sync;
    logic rxd_prev_ff;
    logic [1:0] div_cnt_ff;
    logic tick_ff;
    logic [3:0] phase_ff;
    fmsp_state_type tx_state_ff;
    fmsp_state_type rx_state_ff;
    logic [10:0] tx_shreg_ff;
    logic [3:0] tx_bits_ff;
    logic [3:0] tx_ovs_ff;
    logic tx_bit_ff;
    logic tx_done_pulse;
    logic q_valid;
    logic [7:0] q_data;
    logic q_pop;
    logic [7:0] rx_shreg_ff;
    logic rx_ninth_ff;
    logic [3:0] rx_idx_ff;
    logic [3:0] rx_ovs_ff;
    logic rx_finish;
    logic rx_accept;
    logic rx_ninth_value;
    logic rx_bit_now;
    logic shift_active;

    // Reset release through two stages
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    assign rst_n = rst_sync_ff;

    fmsp_sync #(.WIDTH(1)) u_rxd_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .async_in(rxd_in),
        .sync_out(rxd_sync)
    );

    // Writes queue here; queue full stalls the writer via ready
    fmsp_fifo #(.WIDTH(fmsp_pkg::DATA_W), .DEPTH(fmsp_pkg::TXQ_DEPTH)) u_txq (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .in_valid_in(serial_buffer_write_in),
        .in_data_in(serial_buffer_wdata_in),
        .in_ready_out(serial_buffer_ready_out),
        .out_valid_out(q_valid),
        .out_data_out(q_data),
        .out_ready_in(q_pop)
    );

    // Sixteen-times tick for the asynchronous modes
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_ff <= 2'h0;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= 1'b0;
            if (mode_in == fmsp_pkg::MODE_UART9_FIXED) begin
                if (div_cnt_ff >= (baud_doubler_in ? fmsp_pkg::FIXED_LIM_FAST
                                                   : fmsp_pkg::FIXED_LIM_SLOW)) begin
                    div_cnt_ff <= 2'h0;
                    tick_ff <= 1'b1;
                end else begin
                    div_cnt_ff <= div_cnt_ff + 2'h1;
                end
            end else if (mode_in != fmsp_pkg::MODE_SHIFT && timer1_overflow_in) begin
                if (div_cnt_ff >= (baud_doubler_in ? fmsp_pkg::OVF_LIM_FAST
                                                   : fmsp_pkg::OVF_LIM_SLOW)) begin
                    div_cnt_ff <= 2'h0;
                    tick_ff <= 1'b1;
                end else begin
                    div_cnt_ff <= div_cnt_ff + 2'h1;
                end
            end
        end
    end

    // Mode 0 phase counter, twelve clocks per bit
    assign shift_active = (tx_state_ff == FMSP_SYNC) || (rx_state_ff == FMSP_SYNC);
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= 4'h0;
        end else if (!shift_active || phase_ff == fmsp_pkg::SHIFT_LAST) begin
            phase_ff <= 4'h0;
        end else begin
            phase_ff <= phase_ff + 4'h1;
        end
    end

    // Transmitter; pops the queue only when idle
    assign q_pop = (tx_state_ff == FMSP_IDLE) && q_valid
                   && !(mode_in == fmsp_pkg::MODE_SHIFT && rx_state_ff != FMSP_IDLE);
    assign tx_done_pulse = (tx_state_ff == FMSP_SYNC && phase_ff == fmsp_pkg::SHIFT_LAST
                            && tx_bits_ff == 4'h1)
                           || (tx_state_ff == FMSP_ASYNC && tick_ff
                               && tx_ovs_ff == fmsp_pkg::OVS_LAST && tx_bits_ff == 4'h0);

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_state_ff <= FMSP_IDLE;
            tx_shreg_ff <= fmsp_pkg::TX_SHREG_RESET;
            tx_bits_ff <= 4'h0;
            tx_bit_ff <= 1'b1;
        end else begin
            case (tx_state_ff)
                FMSP_IDLE: begin
                    if (q_pop && mode_in == fmsp_pkg::MODE_SHIFT) begin
                        tx_shreg_ff <= {3'h7, q_data};
                        tx_bits_ff <= fmsp_pkg::SHIFT_BITS;
                        tx_state_ff <= FMSP_SYNC;
                    end else if (q_pop) begin
                        // Stop, ninth (or stop again), data, start
                        tx_shreg_ff <= {1'b1, fmsp_nine_bit(mode_in) ? transmit_ninth_bit_in
                                       : 1'b1, q_data, 1'b0};
                        tx_bits_ff <= fmsp_frame_bits(mode_in);
                        tx_state_ff <= FMSP_ASYNC;
                    end
                end
                FMSP_SYNC: begin
                    if (phase_ff == fmsp_pkg::SHIFT_LAST) begin
                        tx_shreg_ff <= {1'b1, tx_shreg_ff[10:1]};
                        tx_bits_ff <= tx_bits_ff - 4'h1;
                        if (tx_bits_ff == 4'h1) begin
                            tx_state_ff <= FMSP_IDLE;
                        end
                    end
                end
                FMSP_ASYNC: begin
                    // Bit edges follow the free-running divide-by-16
                    if (tick_ff && tx_ovs_ff == fmsp_pkg::OVS_LAST) begin
                        tx_bit_ff <= tx_shreg_ff[0];
                        tx_shreg_ff <= {1'b1, tx_shreg_ff[10:1]};
                        tx_bits_ff <= tx_bits_ff - 4'h1;
                        if (tx_bits_ff == 4'h0) begin
                            tx_bit_ff <= 1'b1;
                            tx_state_ff <= FMSP_IDLE;
                        end
                    end
                end
                default: begin
                    tx_state_ff <= FMSP_IDLE;
                end
            endcase
        end
    end

    // Free-running oversample count for transmit bit timing
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            tx_ovs_ff <= 4'h0;
        end else if (tick_ff) begin
            tx_ovs_ff <= tx_ovs_ff + 4'h1;
        end
    end

    // Receiver
    assign rx_bit_now = rxd_sync;
    assign rx_finish = (rx_state_ff == FMSP_SYNC && phase_ff == fmsp_pkg::SHIFT_LAST
                        && rx_idx_ff == fmsp_pkg::SHIFT_BITS - 4'h1)
                       || (rx_state_ff == FMSP_ASYNC && tick_ff
                           && rx_ovs_ff == fmsp_pkg::OVS_MIDDLE
                           && rx_idx_ff == fmsp_frame_bits(mode_in) - 4'h1);
    // Mode 1 keeps the stop bit as ninth, nine-bit modes the real ninth
    assign rx_ninth_value = fmsp_nine_bit(mode_in) ? rx_ninth_ff : rx_bit_now;
    // Newer character dropped while the old one is unread
    assign rx_accept = !receive_done_flag_out
                       && (rx_state_ff == FMSP_SYNC
                           || !multiprocessor_filter_in
                           || rx_ninth_value);

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rx_state_ff <= FMSP_IDLE;
            rx_shreg_ff <= fmsp_pkg::HOLD_RESET;
            rx_ninth_ff <= 1'b0;
            rx_idx_ff <= 4'h0;
            rx_ovs_ff <= 4'h0;
            rxd_prev_ff <= 1'b1;
        end else begin
            rxd_prev_ff <= rxd_sync;
            case (rx_state_ff)
                FMSP_IDLE: begin
                    rx_idx_ff <= 4'h0;
                    rx_ovs_ff <= 4'h0;
                    if (mode_in == fmsp_pkg::MODE_SHIFT) begin
                        // Shares the data pin, so waits for transmit
                        if (receive_enable_in && !receive_done_flag_out
                            && tx_state_ff == FMSP_IDLE && !q_pop) begin
                            rx_state_ff <= FMSP_SYNC;
                        end
                    end else if (receive_enable_in && rxd_prev_ff && !rxd_sync) begin
                        rx_state_ff <= FMSP_ASYNC;
                    end
                end
                FMSP_SYNC: begin
                    if (phase_ff == fmsp_pkg::SHIFT_LAST) begin
                        rx_shreg_ff <= {rx_bit_now, rx_shreg_ff[7:1]};
                        rx_idx_ff <= rx_idx_ff + 4'h1;
                        if (rx_finish) begin
                            rx_state_ff <= FMSP_IDLE;
                        end
                    end
                end
                FMSP_ASYNC: begin
                    if (tick_ff) begin
                        rx_ovs_ff <= rx_ovs_ff + 4'h1;
                        if (rx_ovs_ff == fmsp_pkg::OVS_MIDDLE) begin
                            rx_idx_ff <= rx_idx_ff + 4'h1;
                            if (rx_idx_ff == 4'h0 && rx_bit_now) begin
                                rx_state_ff <= FMSP_IDLE; // False start, glitch
                            end else if (rx_idx_ff <= fmsp_pkg::SHIFT_BITS) begin
                                if (rx_idx_ff != 4'h0) begin
                                    rx_shreg_ff <= {rx_bit_now, rx_shreg_ff[7:1]};
                                end
                            end else if (rx_finish) begin
                                rx_state_ff <= FMSP_IDLE;
                            end else begin
                                rx_ninth_ff <= rx_bit_now;
                            end
                        end
                    end
                end
                default: begin
                    rx_state_ff <= FMSP_IDLE;
                end
            endcase
        end
    end

    // Holding register, separate from the shift register
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            serial_buffer_rdata_out <= fmsp_pkg::HOLD_RESET;
            received_ninth_bit_out <= 1'b0;
        end else if (rx_finish && rx_accept) begin
            if (rx_state_ff == FMSP_SYNC) begin
                serial_buffer_rdata_out <= {rx_bit_now, rx_shreg_ff[7:1]};
            end else begin
                serial_buffer_rdata_out <= rx_shreg_ff;
                received_ninth_bit_out <= rx_ninth_value;
            end
        end
    end

    // Done flags; a set in the clearing cycle wins
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            transmit_done_flag_out <= 1'b0;
            receive_done_flag_out <= 1'b0;
        end else begin
            if (tx_done_pulse) begin
                transmit_done_flag_out <= 1'b1;
            end else if (transmit_done_clear_in) begin
                transmit_done_flag_out <= 1'b0;
            end
            if (rx_finish && rx_accept) begin
                receive_done_flag_out <= 1'b1;
            end else if (receive_done_clear_in) begin
                receive_done_flag_out <= 1'b0;
            end
        end
    end

    // Pins; in the asynchronous modes independent paths keep both directions running
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            txd_out <= 1'b1;
            rxd_out <= 1'b1;
            rxd_oe_n_out <= 1'b1;
        end else if (mode_in == fmsp_pkg::MODE_SHIFT) begin
            // Shift clock low first half of each bit, high second half
            txd_out <= !shift_active || (phase_ff >= fmsp_pkg::SHIFT_HIGH_FROM);
            rxd_out <= (tx_state_ff == FMSP_SYNC) ? tx_shreg_ff[0] : 1'b1;
            rxd_oe_n_out <= (tx_state_ff != FMSP_SYNC);
        end else begin
            txd_out <= tx_bit_ff;
            rxd_out <= 1'b1;
            rxd_oe_n_out <= 1'b1;
        end
    end
endmodule : fmsp_serial_port
`default_nettype wire

//--- sim/fmsp_serial_port_chk.sv
`timescale 1ns/1ns
`default_nettype none
module fmsp_serial_port_chk (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [1:0] mode_in,
    input wire logic multiprocessor_filter_in,
    input wire logic transmit_done_clear_in,
    input wire logic receive_done_clear_in,
    input wire logic [7:0] serial_buffer_rdata_out,
    input wire logic received_ninth_bit_out,
    input wire logic transmit_done_flag_out,
    input wire logic receive_done_flag_out,
    input wire logic rxd_oe_n_out,
    input wire logic txd_out
);
    // One clock domain, so one default for all
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // Data pin driven only in shift mode
    chk_oe_mode_zero: assert property (mode_in != 2'h0 |-> rxd_oe_n_out)
        else $error("data pin driven outside shift mode");
    // Shift clock six low, six high per bit
    chk_clk_low_phase: assert property (mode_in == 2'h0 && $fell(txd_out) |-> !txd_out [*6] ##1 txd_out)
        else $error("shift clock low phase length wrong");
    chk_clk_high_phase: assert property (mode_in == 2'h0 && $rose(txd_out) |-> txd_out [*6])
        else $error("shift clock high phase too short");
    // Flags hold until software clears them
    chk_tx_flag_sticky: assert property (transmit_done_flag_out && !transmit_done_clear_in |=> transmit_done_flag_out)
        else $error("transmit done dropped by itself");
    chk_rx_flag_sticky: assert property (receive_done_flag_out && !receive_done_clear_in |=> receive_done_flag_out)
        else $error("receive done dropped by itself");
    chk_tx_clear_only: assert property ($fell(transmit_done_flag_out) |-> $past(transmit_done_clear_in))
        else $error("transmit done fell without clear");
    chk_rx_clear_only: assert property ($fell(receive_done_flag_out) |-> $past(receive_done_clear_in))
        else $error("receive done fell without clear");
    // Unread character survives a later frame
    chk_unread_kept: assert property (receive_done_flag_out && !receive_done_clear_in |=> $stable(serial_buffer_rdata_out) && $stable(received_ninth_bit_out))
        else $error("unread character overwritten");
    chk_filter_ninth: assert property ($rose(receive_done_flag_out) && multiprocessor_filter_in && mode_in != 2'h0 |-> received_ninth_bit_out)
        else $error("filtered frame accepted with ninth bit low");

    cov_rx_done: cover property ($rose(receive_done_flag_out));
    cov_tx_done: cover property ($rose(transmit_done_flag_out));
    cov_pin_drive: cover property ($fell(rxd_oe_n_out));
endmodule : fmsp_serial_port_chk

bind fmsp_serial_port fmsp_serial_port_chk i_chk (.*);
`default_nettype wire

//--- sim/fmsp_remote_node.sv
`timescale 1ns/1ns
`default_nettype none
module fmsp_remote_node (
    input wire logic clk_in,
    input wire logic txd_in,
    input wire logic pin_in,
    output logic line_out
);
    // Line idles at mark level
    initial line_out = 1'h1;

    // Frame out, start bit first
    task automatic send(input logic [10:0] f, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            line_out = f[i];
            repeat (per) @(negedge clk_in);
        end
        line_out = 1'h1;
        @(negedge clk_in); // Idle gap so back-to-back frames never collide
    endtask : send

    // Frame in, sampled mid-bit away from edges
    task automatic recv(output logic [10:0] f, input int n, input int per);
        f = 11'h7ff;
        wait (txd_in === 1'h0);
        repeat (per / 2) @(negedge clk_in);
        for (int i = 0; i < n; i++) begin
            f[i] = txd_in;
            repeat (per) @(negedge clk_in);
        end
    endtask : recv

    // Shift mode: new bit after each falling shift clock
    task automatic shift_in(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd_in);
            line_out = d[i];
        end
        @(posedge txd_in);
        repeat (8) @(negedge clk_in);
        line_out = ~d[7]; // Stale value would hide a late sample
    endtask : shift_in

    task automatic shift_out(output logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(posedge txd_in);
            d[i] = pin_in;
        end
    endtask : shift_out
endmodule : fmsp_remote_node
`default_nettype wire

//--- sim/four_mode_serial_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
module four_mode_serial_port_bench;
    typedef struct packed {
        logic [1:0] mode;
        logic dbl;
        logic filt;
        logic [7:0] data;
        logic nin;
        logic stp;
        logic ok;
    } fmsp_row_type;
    // Mode, doubler, filter, data, ninth, stop, accepted
    localparam fmsp_row_type ROWS [7] = '{
        '{2'h1, 1'h0, 1'h0, 8'ha5, 1'h0, 1'h1, 1'h1},
        '{2'h1, 1'h1, 1'h1, 8'h5a, 1'h0, 1'h0, 1'h0},
        '{2'h1, 1'h1, 1'h0, 8'h0f, 1'h0, 1'h0, 1'h1},
        '{2'h2, 1'h0, 1'h0, 8'hc3, 1'h0, 1'h0, 1'h1},
        '{2'h2, 1'h1, 1'h1, 8'h81, 1'h0, 1'h1, 1'h0},
        '{2'h3, 1'h1, 1'h1, 8'h42, 1'h1, 1'h1, 1'h1},
        '{2'h3, 1'h0, 1'h0, 8'h3c, 1'h0, 1'h1, 1'h1}
    };
    logic clk = 1'h0;
    logic rst_n, filt, ren, tb8, dbl, wr, tdclr, rdclr;
    logic [1:0] mode;
    logic [7:0] wdata, rdata, old, b8;
    logic ready, ninth, tdone, rdone, rxd_o, oe_n, txd, line;
    logic [10:0] got, frame;
    fmsp_row_type r;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int per, n;
    // Shared data pin
    wire logic pin;
    assign pin = oe_n ? line : rxd_o;

    fmsp_serial_port i_dut (.clk_in(clk), .rst_n_in(rst_n), .mode_in(mode),
        .multiprocessor_filter_in(filt), .receive_enable_in(ren), .transmit_ninth_bit_in(tb8),
        .baud_doubler_in(dbl), .timer1_overflow_in(1'h1), .serial_buffer_write_in(wr),
        .serial_buffer_wdata_in(wdata), .serial_buffer_ready_out(ready),
        .serial_buffer_rdata_out(rdata), .received_ninth_bit_out(ninth),
        .transmit_done_flag_out(tdone), .receive_done_flag_out(rdone),
        .transmit_done_clear_in(tdclr), .receive_done_clear_in(rdclr), .rxd_in(pin),
        .rxd_out(rxd_o), .rxd_oe_n_out(oe_n), .txd_out(txd));
    fmsp_remote_node i_node (.clk_in(clk), .txd_in(txd), .pin_in(pin), .line_out(line));

    always #2 clk = ~clk;

    task automatic check(input logic [10:0] s, input logic [10:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : check

    task automatic end_of_test();
        if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic write_byte(input logic [7:0] d);
        @(negedge clk);
        wr = 1'h1;
        wdata = d;
        @(negedge clk);
        wr = 1'h0;
    endtask : write_byte

    task automatic pulse_clear();
        @(negedge clk);
        {tdclr, rdclr} = 2'h3;
        @(negedge clk);
        {tdclr, rdclr} = 2'h0;
    endtask : pulse_clear

    // Clocks per bit, timer overflowing each clock
    function automatic int bit_per(input logic [1:0] m, input logic d);
        return (m == 2'h2) ? (d ? 32 : 64) : (d ? 16 : 32);
    endfunction : bit_per

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    initial begin
        {rst_n, filt, ren, tb8, dbl, wr, tdclr, rdclr} = 8'h00;
        mode = 2'h0;
        wdata = 8'h00;
        repeat (4) @(negedge clk);
        check({ready, txd, rxd_o, oe_n, tdone, rdone, ninth}, 11'h078);
        check(rdata, 11'h000);
        rst_n = 1'h1;
        repeat (4) @(negedge clk);
        // Both directions at once, one row each
        foreach (ROWS[i]) begin
            r = ROWS[i];
            {mode, dbl, filt, tb8, ren} = {r.mode, r.dbl, r.filt, r.nin, 1'h1};
            per = bit_per(r.mode, r.dbl);
            n = (r.mode == 2'h1) ? 10 : 11;
            frame = (r.mode == 2'h1) ? {2'h3, r.data, 1'h0} : {r.stp, r.nin, r.data, 1'h0};
            if (r.mode == 2'h1) frame[9] = r.stp;
            old = rdata;
            fork
                i_node.send(frame, n, per);
                begin
                    write_byte(~r.data);
                    i_node.recv(got, n, per);
                end
            join
            repeat (per) @(negedge clk);
            check(rdone, r.ok);
            check(rdata, r.ok ? r.data : old);
            if (r.ok) check(ninth, (r.mode == 2'h1) ? r.stp : r.nin);
            check(got, (r.mode == 2'h1) ? {2'h3, ~r.data, 1'h0} : {1'h1, r.nin, ~r.data, 1'h0});
            check(tdone, 1'h1);
            pulse_clear();
        end
        // Second frame lands on an unread one
        {mode, dbl, filt} = {2'h1, 1'h1, 1'h0};
        i_node.send({2'h3, 8'h11, 1'h0}, 10, 16);
        i_node.send({2'h3, 8'h22, 1'h0}, 10, 16);
        repeat (16) @(negedge clk);
        check(rdata, 11'h011);
        check(rdone, 1'h1);
        pulse_clear();
        // Fill the queue until it refuses, then drain
        for (int k = 0; k < 10; k++) begin
            @(negedge clk);
            wr = 1'h1;
            wdata = 8'(k);
        end
        @(negedge clk);
        wr = 1'h0;
        check(ready, 1'h0);
        repeat (1700) @(negedge clk);
        check({ready, tdone}, 11'h003);
        // Shift mode out; receiver off so the pin stays free
        {ren, mode} = 3'h0;
        pulse_clear();
        fork
            write_byte(8'h96);
            i_node.shift_out(b8);
        join
        repeat (20) @(negedge clk);
        check(b8, 11'h096);
        check({tdone, oe_n}, 11'h003);
        // Shift mode in, filter set to show it is ignored
        {filt, ren} = 2'h3;
        i_node.shift_in(8'h5a);
        for (int k = 0; k < 200 && rdone !== 1'h1; k++) @(negedge clk);
        ren = 1'h0;
        check({rdone, rdata}, 11'h15a);
        end_of_test();
    end
endmodule : four_mode_serial_port_bench
`default_nettype wire
